// *** watchdog_pkg.sv ***
// constants of the watchdog timeout reset block
// How it works
// - 12-bit prescaler feeds free-running 6-bit counter
// - overflow resets after 262128 or 8176 cycles
// - service write clears counter and prescaler 12-5
// - timeout drives reset pin low 32 cycles, flags
// - service read returns reset vector low byte
// - stop instruction clears the prescaler
// - power-on clears prescaler after 4096 cycles
// - internal reset clears prescaler and counter
// - reset vector fetch clears the prescaler
// - disable input follows configuration disable bit
// - rate select follows configuration rate bit
// - watchdog never requests a cpu interrupt
// - irq test-voltage monitor entry disables while applied
// - blank-vector monitor entry disables until power-on
// - break with reset-pin test voltage disables
// - wait mode keeps counting and may reset
// - stop mode gates clock, clears prescaler
// - disabled stop instruction gives illegal-opcode reset
// - disable bit one disables, zero enables
// - rate bit one short, zero long, reset clears
package watchdog_pkg;

  // ****************************************
  // register map (index, byte address)
  // ****************************************
  localparam logic [15:0] IDX_SERVICE  = 16'hffff;
  localparam logic [15:0] IDX_CONFIG   = 16'h0001;
  localparam logic [15:0] IDX_STATUS   = 16'h0002;
  localparam logic [17:0] ADDR_SERVICE = {IDX_SERVICE, 2'b00};
  localparam logic [17:0] ADDR_CONFIG  = {IDX_CONFIG, 2'b00};
  localparam logic [17:0] ADDR_STATUS  = {IDX_STATUS, 2'b00};

  // ****************************************
  // field positions
  // ****************************************
  localparam int CFG_DISABLE_POS = 0;
  localparam int CFG_RATE_POS    = 1;
  localparam int CFG_STOPEN_POS  = 2;
  localparam int CFG_LOCK_POS    = 3;
  localparam int ST_CAUSE_POS    = 0;
  localparam int ST_RUN_POS      = 1;
  localparam int ST_PIN_POS      = 2;
  localparam int ST_CNT_LSB      = 8;

  // ****************************************
  // reset values and cycle counts
  // ****************************************
  localparam logic [2:0]  CFG_RESET         = 3'h0;
  localparam logic [17:0] TIMEOUT_LONG_CYC  = 18'd262128;
  localparam logic [17:0] TIMEOUT_SHORT_CYC = 18'd8176;
  localparam logic [12:0] POR_DELAY_CYC     = 13'd4096;
  localparam logic [5:0]  RST_PULSE_CYC     = 6'd32;
  // arbitrary value, stands in for the reset vector low byte
  localparam logic [7:0]  RESET_VEC_LO      = 8'h3c;

  // pin sync lanes: irq test voltage, reset test voltage, reset pin
  localparam int SYNC_N   = 3;
  localparam int LN_TIRQ  = 0;
  localparam int LN_TRST  = 1;
  localparam int LN_RPIN  = 2;

endpackage

// *** watchdog_timeout_reset.sv ***
// watchdog timeout reset block with apb register slave
`timescale 1ns/10ps
module watchdog_timeout_reset #(
  parameter logic [17:0] P_TIMEOUT_LONG  =
    watchdog_pkg::TIMEOUT_LONG_CYC,
  parameter logic [17:0] P_TIMEOUT_SHORT =
    watchdog_pkg::TIMEOUT_SHORT_CYC
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [17:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output      logic [31:0] o_prdata,
  output      logic        o_pready,
  output      logic        o_pslverr,
  input  wire logic        i_stop_exec,
  input  wire logic        i_stop_mode,
  input  wire logic        i_vector_fetch,
  input  wire logic        i_internal_reset,
  input  wire logic        i_monitor_entry,
  input  wire logic        i_vectors_blank,
  input  wire logic        i_break_active,
  input  wire logic        i_tst_irq,
  input  wire logic        i_tst_rst,
  input  wire logic        i_rst_pin_i,
  output      logic        o_rst_pin_o,
  output      logic        o_rst_pin_oe,
  output      logic        o_wd_reset,
  output      logic        o_illegal_reset,
  output      logic        o_stop_grant
);
  import watchdog_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [11:0]        pre;
    logic [5:0]         cnt;
    logic [5:0]         pulse;
    logic [12:0]        por;
    logic               por_done;
    logic [2:0]         cfg;
    logic               cfg_lock;
    logic               cause;
    logic [SYNC_N-1:0]  s1;
    logic [SYNC_N-1:0]  s2;
    logic [SYNC_N-1:0]  s3;
    logic [SYNC_N-1:0]  filt;
    logic               mon_tst;
    logic               mon_blank;
    logic [31:0]        rdata;
    logic               illegal;
    logic               stop_ok;
  } state_type;

  state_type   q;
  state_type   d;
  logic        wr_acc;
  logic        rd_setup;
  logic        hit;
  logic        disabled;
  logic        run;
  logic        timeout;
  logic [17:0] tot;
  logic [17:0] limit_m1;

  // ****************************************
  // bus decode
  // ****************************************
  assign hit = (i_paddr == ADDR_SERVICE) || (i_paddr == ADDR_CONFIG)
            || (i_paddr == ADDR_STATUS);
  assign wr_acc   = i_psel && i_penable && i_pwrite;
  assign rd_setup = i_psel && !i_penable && !i_pwrite;
  // zero wait states: read data is latched in the setup phase
  assign o_pready  = i_psel && i_penable;
  assign o_pslverr = i_psel && i_penable && !hit;

  // ****************************************
  // timeout decision
  // ****************************************
  // disable sources
  assign disabled = q.cfg[CFG_DISABLE_POS] || q.mon_blank
    || (q.mon_tst && (q.filt[LN_TIRQ] || q.filt[LN_TRST]))
    || (i_break_active && q.filt[LN_TRST]);
  // wait mode does not stop counting; stop does
  assign run = !i_stop_mode && !disabled && (q.pulse == 6'd0);
  assign tot = {q.cnt, q.pre};
  assign limit_m1 = q.cfg[CFG_RATE_POS] ? P_TIMEOUT_SHORT - 18'd1
                                        : P_TIMEOUT_LONG - 18'd1;
  // overflow point of the combined count
  assign timeout = run && (tot == limit_m1);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    d = q;
    d.illegal = 1'b0;
    d.stop_ok = 1'b0;
    // pin lanes: three stages, change taken once two agree
    d.s1 = {i_rst_pin_i, i_tst_rst, i_tst_irq};
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < SYNC_N; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.filt[i] = q.s3[i];
      end
    end

    // prescaler carries into the 6-bit counter
    if (q.pulse != 6'd0) begin
      // our own reset is an internal reset too
      d.pulse = q.pulse - 6'd1;
      d.pre   = 12'h000;
      d.cnt   = 6'd0;
    end else if (timeout) begin
      // start pin pulse and record the cause
      d.pulse = RST_PULSE_CYC;
      d.cause = 1'b1;
      d.pre   = 12'h000;
      d.cnt   = 6'd0;
    end else if (run) begin
      {d.cnt, d.pre} = tot + 18'd1;
    end

    // service write; stages 4-1 run on
    if (wr_acc && i_paddr == ADDR_SERVICE && q.pulse == 6'd0
        && !timeout) begin
      d.cnt      = 6'd0;
      d.pre[11:4] = 8'h00;
    end

    // prescaler cleared once power-up delay ends
    if (!q.por_done) begin
      d.por = q.por + 13'd1;
      if (d.por == POR_DELAY_CYC) begin
        d.por_done = 1'b1;
        d.pre      = 12'h000;
      end
    end

    if (i_stop_exec) begin
      if (q.cfg[CFG_STOPEN_POS]) begin
        d.pre     = 12'h000;
        d.stop_ok = 1'b1;
      end else begin
        d.illegal = 1'b1;
      end
    end
    // stop mode holds the prescaler clear
    if (i_stop_mode) begin
      d.pre = 12'h000;
    end
    if (i_vector_fetch) begin
      d.pre = 12'h000;
    end
    // other internal resets clear both stages
    if (i_internal_reset) begin
      d.pre = 12'h000;
      d.cnt = 6'd0;
    end

    if (i_monitor_entry) begin
      if (q.filt[LN_TIRQ]) begin
        d.mon_tst = 1'b1;
      end else if (i_vectors_blank) begin
        d.mon_blank = 1'b1;
      end
    end else if (!q.filt[LN_TIRQ] && !q.filt[LN_TRST]) begin
      d.mon_tst = 1'b0;
    end

    // configuration is write-once after reset
    if (wr_acc && i_paddr == ADDR_CONFIG && !q.cfg_lock) begin
      d.cfg      = i_pwdata[2:0];
      d.cfg_lock = 1'b1;
    end
    // cause is write-one-to-clear; a new timeout wins
    if (wr_acc && i_paddr == ADDR_STATUS && i_pwdata[ST_CAUSE_POS]
        && !timeout) begin
      d.cause = 1'b0;
    end

    if (rd_setup) begin
      d.rdata = 32'h0000_0000;
      unique case (i_paddr)
        // service location reads the vector byte
        ADDR_SERVICE: d.rdata[7:0] = RESET_VEC_LO;
        ADDR_CONFIG: begin
          d.rdata[2:0]          = q.cfg;
          d.rdata[CFG_LOCK_POS] = q.cfg_lock;
        end
        ADDR_STATUS: begin
          d.rdata[ST_CAUSE_POS]             = q.cause;
          d.rdata[ST_RUN_POS]               = run;
          d.rdata[ST_PIN_POS]               = q.filt[LN_RPIN];
          d.rdata[ST_CNT_LSB+5:ST_CNT_LSB]  = q.cnt;
        end
        default: d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      q          <= '0;
      // reset clears rate select and the rest
      q.cfg      <= CFG_RESET;
      // reset pin idles high, test lanes low: no false edge
      q.s1       <= 3'h4;
      q.s2       <= 3'h4;
      q.s3       <= 3'h4;
      q.filt     <= 3'h4;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // timeout actions are the reset pulse and the cause flag
  assign o_rst_pin_o     = 1'b0;
  assign o_rst_pin_oe    = (q.pulse != 6'd0);
  assign o_wd_reset      = (q.pulse != 6'd0);
  assign o_prdata        = q.rdata;
  assign o_illegal_reset = q.illegal;
  assign o_stop_grant    = q.stop_ok;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic svc_wr;
  assign svc_wr = wr_acc && (i_paddr == ADDR_SERVICE);

  logic por_hit;
  // power-on delay ends this cycle and clears the prescaler
  assign por_hit = !q.por_done && (q.por == POR_DELAY_CYC - 13'd1);

  sequence s_pulse_hold;
    o_rst_pin_oe ##31 o_rst_pin_oe ##1 !o_rst_pin_oe;
  endsequence

  sequence s_timeout_start;
    timeout ##1 o_rst_pin_oe;
  endsequence

  AST_PULSE_32: assert property (
    $rose(o_rst_pin_oe) |-> s_pulse_hold)
    else $error("reset pin pulse is not 32 cycles");

  AST_CAUSE_SET: assert property (
    s_timeout_start |-> q.cause && o_wd_reset)
    else $error("timeout did not flag its cause");

  AST_SERVICE_CLR: assert property (
    svc_wr && q.pulse == 6'd0 && !timeout |=>
      q.cnt == 6'd0 && q.pre[11:4] == 8'h00)
    else $error("service write did not clear count");

  AST_LOW_RUN: assert property (
    svc_wr && run && !timeout && !por_hit && !i_stop_exec
      && !i_vector_fetch && !i_internal_reset |=>
      q.pre[3:0] == $past(q.pre[3:0]) + 4'd1)
    else $error("low prescaler stages stopped on service");

  AST_STOP_CLR: assert property (
    i_stop_mode |=> q.pre == 12'h000)
    else $error("stop mode left prescaler running");

  AST_VEC_CLR: assert property (
    i_vector_fetch |=> q.pre == 12'h000)
    else $error("vector fetch did not clear prescaler");

  AST_INT_RST: assert property (
    i_internal_reset |=> q.pre == 12'h000 && q.cnt == 6'd0)
    else $error("internal reset did not clear watchdog");

  AST_DISABLED: assert property (
    q.cfg[CFG_DISABLE_POS] && !o_rst_pin_oe |=> !o_rst_pin_oe)
    else $error("disabled watchdog raised a reset");

  AST_READ_VEC: assert property (
    rd_setup && i_paddr == ADDR_SERVICE |=>
      o_prdata == {24'h000000, RESET_VEC_LO})
    else $error("service read not the vector byte");

  AST_ILLEGAL: assert property (
    i_stop_exec && !q.cfg[CFG_STOPEN_POS] |=>
      o_illegal_reset && !o_stop_grant)
    else $error("disabled stop did not give illegal reset");

  AST_BLANK_HOLD: assert property (
    q.mon_blank |=> q.mon_blank && !run)
    else $error("blank-vector monitor disable was lost");

  AST_TIMEOUT_AT: assert property (
    run && tot == limit_m1 |=> o_rst_pin_oe && q.cnt == 6'd0)
    else $error("overflow did not start reset");

  AST_POR_CLR: assert property (
    por_hit |=> q.pre == 12'h000 && q.por_done)
    else $error("power-on delay did not clear prescaler");

  AST_STOP_EXEC: assert property (
    i_stop_exec && q.cfg[CFG_STOPEN_POS] |=>
      q.pre == 12'h000 && o_stop_grant && !o_illegal_reset)
    else $error("stop instruction did not clear prescaler");

  AST_NO_STOP: assert property (
    !i_stop_exec |=> !o_illegal_reset && !o_stop_grant)
    else $error("stop outcome pulse without stop");

  AST_PIN_LEVEL: assert property (
    o_rst_pin_oe |-> !o_rst_pin_o && o_wd_reset)
    else $error("reset pin not driven low with reset");

  AST_CAUSE_HOLD: assert property (
    q.cause && !(wr_acc && i_paddr == ADDR_STATUS
      && i_pwdata[ST_CAUSE_POS]) |=> q.cause)
    else $error("cause flag lost without clear");

  AST_RATE_SHORT: assert property (
    run && q.cfg[CFG_RATE_POS] && tot == P_TIMEOUT_SHORT - 18'd1
      |=> o_wd_reset && q.cause)
    else $error("short period did not end in reset");

  AST_RATE_LONG: assert property (
    run && !q.cfg[CFG_RATE_POS] && tot == P_TIMEOUT_LONG - 18'd1
      |=> o_wd_reset && q.cause)
    else $error("long period did not end in reset");

  AST_COUNT_STEP: assert property (
    run && !timeout && !svc_wr && !por_hit && !i_stop_exec
      && !i_vector_fetch && !i_internal_reset |=>
      tot == $past(tot) + 18'd1)
    else $error("combined count did not advance by one");

  AST_DIS_HOLD: assert property (
    disabled && !i_stop_mode && !o_wd_reset && !svc_wr && !por_hit
      && !i_stop_exec && !i_vector_fetch && !i_internal_reset |=>
      tot == $past(tot))
    else $error("disabled counter did not hold");

  AST_CFG_LOCK: assert property (
    wr_acc && i_paddr == ADDR_CONFIG && q.cfg_lock |=>
      q.cfg == $past(q.cfg))
    else $error("locked configuration was changed");

  AST_BREAK_DIS: assert property (
    i_break_active && q.filt[LN_TRST] |-> !run)
    else $error("break with test voltage still counting");

  AST_MON_TST: assert property (
    q.mon_tst && (q.filt[LN_TIRQ] || q.filt[LN_TRST]) |-> !run)
    else $error("test-voltage monitor still counting");

  AST_WAIT_RUN: assert property (
    !disabled && !i_stop_mode && !o_wd_reset |-> run)
    else $error("enabled watchdog stopped counting");

  AST_STOP_MODE: assert property (
    i_stop_mode |-> !run)
    else $error("watchdog counted in stop mode");

endmodule // watchdog_timeout_reset

// *** wd_cpu.sv ***
// cpu core model driving the register bus as apb master
`timescale 1ns/10ps
module wd_cpu (
  input  wire logic        i_clk,
  output      logic        o_psel,
  output      logic        o_penable,
  output      logic        o_pwrite,
  output      logic [17:0] o_paddr,
  output      logic [31:0] o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  initial begin
    o_psel    = 1'b0;
    o_penable = 1'b0;
    o_pwrite  = 1'b0;
    o_paddr   = 18'h00000;
    o_pwdata  = 32'h00000000;
  end

  // service and bus cycles
  // request held until pready is sampled; wait bounded by bench timer
  task automatic xfer(input logic w, input logic [17:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge i_clk);
    o_psel    <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite  <= w;
    o_paddr   <= a;
    o_pwdata  <= d;
    @(posedge i_clk);
    o_penable <= 1'b1;
    do @(posedge i_clk); while (i_pready !== 1'b1);
    r = i_prdata;
    e = i_pslverr;
    o_psel    <= 1'b0;
    o_penable <= 1'b0;
    // bus data not held once released
    o_pwdata  <= ~d;
  endtask
endmodule // wd_cpu

// *** watchdog_timeout_reset_tb.sv ***
// self-checking testbench of the watchdog timeout reset block
`timescale 1ns/10ps
module watchdog_timeout_reset_tb;
  import watchdog_pkg::*;
  // ****************************************
  // shortened periods, pulse stays 32
  // ****************************************
  localparam int LG = 300;
  localparam int SH = 40;
  logic        i_clk, i_rst, psel, penable, pwrite, pready, pslverr;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        err, stp, stpm, vf, irst, mon, blank, brk, tirq, trst;
  logic        pin_o, pin_oe, wdr, wd_q, ill, grant;
  int          mismatches, samples_checked, rises, cyc, n;

  wd_cpu cpu (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

  watchdog_timeout_reset #(.P_TIMEOUT_LONG(18'(LG)),
    .P_TIMEOUT_SHORT(18'(SH))) uut (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_stop_exec(stp),
    .i_stop_mode(stpm), .i_vector_fetch(vf), .i_internal_reset(irst),
    .i_monitor_entry(mon), .i_vectors_blank(blank),
    .i_break_active(brk), .i_tst_irq(tirq), .i_tst_rst(trst),
    // open-drain pin with pull-up
    .i_rst_pin_i(pin_oe ? pin_o : 1'b1), .o_rst_pin_o(pin_o),
    .o_rst_pin_oe(pin_oe), .o_wd_reset(wdr),
    .o_illegal_reset(ill), .o_stop_grant(grant));

  initial begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    wd_q <= wdr;
    if (wdr === 1'b1 && wd_q !== 1'b1) rises++;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic chk(input bit ok, input string m);
    samples_checked++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  task automatic rst_dut();
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
  endtask

  task automatic wait_rise(output int k);
    k = 0;
    while (wdr !== 1'b1) begin
      @(negedge i_clk);
      k++;
    end
  endtask

  // quiet run: no reset may appear
  task automatic quiet(input int c, input string m);
    int r0;
    r0 = rises;
    repeat (c) @(posedge i_clk);
    chk(rises == r0, m);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    cpu.xfer(1'b0, ADDR_CONFIG, 32'h0, rd, err);
    chk(rd === 32'h0 && err === 1'b0, "config reset");
    cpu.xfer(1'b0, ADDR_SERVICE, 32'h0, rd, err);
    chk(rd === {24'h000000, RESET_VEC_LO}, "service read");
    cpu.xfer(1'b1, 18'h00010, 32'h0, rd, err);
    chk(err === 1'b1, "unmapped");
  endtask

  task automatic t_long();
    rst_dut();
    wait_rise(n);
    chk(n >= LG - 2 && n <= LG + 6, "long period");
    chk(pin_o === 1'b0 && pin_oe === 1'b1, "pin level");
    n = 0;
    while (wdr === 1'b1) begin
      @(negedge i_clk);
      n++;
    end
    chk(n == int'(RST_PULSE_CYC), "pulse width");
    cpu.xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk(rd[ST_CAUSE_POS] === 1'b1, "cause set");
    cpu.xfer(1'b1, ADDR_STATUS, 32'h1, rd, err);
    cpu.xfer(1'b0, ADDR_STATUS, 32'h0, rd, err);
    chk(rd[ST_CAUSE_POS] === 1'b0, "cause w1c");
    chk(rd[ST_PIN_POS] === 1'b1, "pin released");
  endtask

  task automatic t_service();
    int r0;
    rst_dut();
    r0 = rises;
    repeat (4) begin
      repeat (200) @(posedge i_clk);
      cpu.xfer(1'b1, ADDR_SERVICE, 32'h5a, rd, err);
    end
    chk(rises == r0, "serviced");
    wait_rise(n);
    chk(n >= LG - 20 && n <= LG + 4, "after service");
  endtask

  task automatic t_short();
    rst_dut();
    cpu.xfer(1'b1, ADDR_CONFIG, 32'h2, rd, err);
    wait_rise(n);
    while (wdr === 1'b1) @(negedge i_clk);
    wait_rise(n);
    chk(n >= SH - 2 && n <= SH + 4, "short period");
  endtask

  task automatic t_disable();
    rst_dut();
    cpu.xfer(1'b1, ADDR_CONFIG, 32'h1, rd, err);
    cpu.xfer(1'b1, ADDR_CONFIG, 32'h0, rd, err);
    cpu.xfer(1'b0, ADDR_CONFIG, 32'h0, rd, err);
    chk(rd === 32'h9, "config locked");
    // long enough to pass the power-on delay clear as well
    quiet(4200, "disabled");
  endtask

  task automatic t_stop();
    rst_dut();
    @(posedge i_clk) stp <= 1'b1;
    @(posedge i_clk) stp <= 1'b0;
    #1 chk(ill === 1'b1 && grant === 1'b0, "illegal stop");
    cpu.xfer(1'b1, ADDR_CONFIG, 32'h4, rd, err);
    @(posedge i_clk) stp <= 1'b1;
    @(posedge i_clk) stp <= 1'b0;
    #1 chk(grant === 1'b1 && ill === 1'b0, "stop grant");
    @(posedge i_clk) stpm <= 1'b1;
    quiet(2 * LG, "stop mode");
    stpm <= 1'b0;
    wait_rise(n);
    chk(n >= LG - 2 && n <= LG + 6, "stop clears prescaler");
  endtask

  task automatic t_modes();
    rst_dut();
    @(posedge i_clk) brk <= 1'b1;
    trst <= 1'b1;
    quiet(2 * LG, "break held");
    @(posedge i_clk) brk <= 1'b0;
    trst <= 1'b0;
    repeat (250) @(posedge i_clk);
    irst <= 1'b1;
    @(posedge i_clk) irst <= 1'b0;
    quiet(250, "internal reset");
    rst_dut();
    @(posedge i_clk) mon <= 1'b1;
    blank <= 1'b1;
    @(posedge i_clk) mon <= 1'b0;
    quiet(2 * LG, "blank monitor");
    rst_dut();
    @(posedge i_clk) tirq <= 1'b1;
    repeat (8) @(posedge i_clk);
    mon <= 1'b1;
    @(posedge i_clk) mon <= 1'b0;
    quiet(2 * LG, "irq test held");
    tirq <= 1'b0;
    wait_rise(n);
    chk(n >= LG - 24 && n <= LG + 8, "irq test released");
  endtask

  task automatic results();
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    {stp, stpm, vf, irst, mon, blank, brk, tirq, trst} = '0;
    i_rst = 1'b1;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    t_regs();
    t_long();
    t_service();
    t_short();
    t_disable();
    t_stop();
    t_modes();
    results();
  end
endmodule // watchdog_timeout_reset_tb
